/* File: rtl/gain_sw_pkg.sv */
/*
 Package for the gain set switching block: register map, field positions,
 reset values and modes. Assumes a 32-bit classic Wishbone slave with word registers.
*/
package gain_sw_pkg;
    localparam int ADDR_W = 8;
    localparam int GAIN_W = 16;
    localparam int NUM_GAINS = 7;
    // Register byte offsets
    localparam logic [7:0] OFS_GAIN_SWITCH_SELECT = 8'h00;
    localparam logic [7:0] OFS_MODEL_FOLLOW_SWITCH = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_SET1_BASE = 8'h20;
    localparam logic [7:0] OFS_SET2_BASE = 8'h40;
    // Field positions
    localparam int SEL_METHOD_LSB = 0;
    localparam int MF_COMBINE_LSB = 12;
    localparam int CTRL_TUNING_BIT = 0;
    localparam int CTRL_FF_GAIN_LSB = 16;
    // Digit codes
    localparam logic [3:0] METHOD_MANUAL = 4'h0;
    localparam logic [3:0] METHOD_RESERVED = 4'h1;
    localparam logic [3:0] METHOD_AUTO = 4'h2;
    localparam logic [3:0] MF_COMBINE_OFF = 4'h0;
    localparam logic [3:0] MF_COMBINE_ON = 4'h1;
    // Reset values
    localparam logic [15:0] GAIN_SWITCH_SELECT_RST = 16'h0000;
    localparam logic [15:0] MODEL_FOLLOW_SWITCH_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h0000;
    // Gain slot indices within a set
    localparam int IDX_SPEED_GAIN = 0;
    localparam int IDX_SPEED_INTEGRAL = 1;
    localparam int IDX_POSITION_GAIN = 2;
    localparam int IDX_FORCE_FILTER = 3;
    localparam int IDX_MF_GAIN = 4;
    localparam int IDX_MF_COMP = 5;
    localparam int IDX_FRICTION_COMP = 6;
endpackage : gain_sw_pkg

/* File: rtl/gain_set_if.sv */
/*
 Interface carrying both gain sets from the register file to the selector.
 Assumes both ends share core_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface gain_set_if;
    import gain_sw_pkg::*;
    logic [GAIN_W-1:0] set1 [NUM_GAINS];
    logic [GAIN_W-1:0] set2 [NUM_GAINS];
    logic use_set2;
    logic mf_use_set2;
    logic [GAIN_W-1:0] active [NUM_GAINS];
    modport src (output set1, output set2, output use_set2, output mf_use_set2, input active);
    modport sel (input set1, input set2, input use_set2, input mf_use_set2, output active);
endinterface : gain_set_if
`default_nettype wire

/* File: rtl/gain_set_mux.sv */
/*
 Active gain set register: picks each member from set 1 or set 2.
 Assumes select lines from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module gain_set_mux (
    input wire logic core_clk_i,
    input wire logic srst_i,
    gain_set_if.sel gs
);
    import gain_sw_pkg::*;
    typedef struct packed {
        logic [NUM_GAINS-1:0][GAIN_W-1:0] act;
    } mux_state_t;
    mux_state_t st_reg;
    mux_state_t st_next;
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < NUM_GAINS; i++) begin
            if (i == IDX_MF_GAIN || i == IDX_MF_COMP) begin
                st_next.act[i] = gs.mf_use_set2 ? gs.set2[i] : gs.set1[i]; // RULE_11
            end else begin
                st_next.act[i] = gs.use_set2 ? gs.set2[i] : gs.set1[i]; // RULE_08
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next; // RULE_15
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_GAINS; i++) begin
            gs.active[i] = st_reg.act[i];
        end
    end
endmodule : gain_set_mux
`default_nettype wire

/* File: rtl/servo_gain_set_switching.sv */
/*
 Gain set switching and feedforward combination for a linear servo drive,
 with a classic Wishbone register slave. Assumes command inputs and motion
 status come from logic on core_clk_i.
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
// What this block does
// RULE_01 - At reset defaults the feedforward gain and both host feedforward inputs have no effect.
// RULE_02 - Top digit of the model-follow switch enables host feedforward with model following, at once.
// RULE_03 - The host should not add its own feedforward to model following, to avoid overshoot.
// RULE_04 - Lowest digit of the gain-switch select picks manual (0) or automatic (2), at once.
// RULE_05 - Software must never write the reserved code 1 into that digit.
// RULE_06 - Manual mode follows only the gain select input; automatic mode uses internal conditions.
// RULE_07 - Gain select 0 activates set 1 and select 1 activates set 2.
// RULE_08 - Each set holds seven gains and switching exchanges the whole set only when RULE_09 and RULE_10 let the model-following pair switch.
// RULE_09 - Model-following gain and compensation switch only in manual mode.
// RULE_10 - They switch only on a select input with no command running and the motor stopped.
// RULE_11 - Otherwise the other members switch while the two model-following values stay.
// RULE_12 - During tuning only the model-follow switch and the control tuning bit are writable; afterwards tuned values load.
// RULE_13 - During tuning writes to protected model-following and suppression values are refused.
// RULE_14 - Automatic switching runs only in position control.
// RULE_15 - The select is registered per command and applied from the next control cycle.
`timescale 1ns/100ps
`default_nettype none
module servo_gain_set_switching (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gain_sw_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmd_valid_i,
    input wire logic gain_select_i,
    input wire logic cmd_busy_i,
    input wire logic motor_stopped_i,
    input wire logic position_ctrl_i,
    input wire logic auto_cond_a_i,
    input wire logic [15:0] speed_ff_input_i,
    input wire logic [15:0] force_ff_input_i,
    input wire logic tune_done_i,
    input wire logic [15:0] tuned_mf_switch_i,
    input wire logic [15:0] tuned_mf_gain_i,
    input wire logic [15:0] tuned_freq_a_i,
    input wire logic [15:0] tuned_freq_b_i,
    output logic tuning_o,
    output logic [15:0] speed_ff_o,
    output logic [15:0] force_ff_o,
    output logic [15:0] feedforward_gain_o,
    output logic [15:0] suppress1_freq_a_o,
    output logic [15:0] suppress1_freq_b_o,
    output logic active_set2_o,
    output logic mf_set2_o,
    output logic [15:0] speed_gain_o,
    output logic [15:0] speed_integral_o,
    output logic [15:0] position_gain_o,
    output logic [15:0] force_filter_o,
    output logic [15:0] mf_gain_o,
    output logic [15:0] mf_comp_o,
    output logic [15:0] friction_comp_o
);
    import gain_sw_pkg::*;

    typedef struct packed {
        logic [15:0] gain_switch_select;
        logic [15:0] model_follow_switch;
        logic tuning;
        logic [15:0] ff_gain;
        logic [15:0] freq_a;
        logic [15:0] freq_b;
        logic [NUM_GAINS-1:0][15:0] set1;
        logic [NUM_GAINS-1:0][15:0] set2;
        logic sel_latched;
        logic use_set2;
        logic mf_use_set2;
        logic ack;
        logic [31:0] rdata;
        logic [15:0] sff;
        logic [15:0] fff;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    gain_set_if gs ();

    gain_set_mux u_mux (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .gs(gs)
    );

    logic [3:0] method;
    logic combine;
    logic wr;
    logic rd;
    logic [15:0] wdata16;
    logic [ADDR_W-1:0] ofs;
    logic auto_mode;
    logic target_set2;
    logic protected_hit;

    assign method = st_reg.gain_switch_select[SEL_METHOD_LSB +: 4];
    assign combine = st_reg.model_follow_switch[MF_COMBINE_LSB +: 4] == MF_COMBINE_ON;
    assign auto_mode = method == METHOD_AUTO;
    // Write lands at the edge where the master samples ack high
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st_reg.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_reg.ack;
    assign ofs = wb_adr_i;

    always_comb begin
        wdata16 = st_reg.rdata[15:0];
        protected_hit = 1'b0;
        target_set2 = st_reg.sel_latched;
        st_next = st_reg;
        st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
        // Manual path uses registered select; automatic only in position control
        if (auto_mode && position_ctrl_i) begin
            target_set2 = auto_cond_a_i; // RULE_14
        end
        if (cmd_valid_i && !auto_mode) begin
            st_next.sel_latched = gain_select_i; // RULE_15
            target_set2 = gain_select_i;
        end
        st_next.use_set2 = target_set2; // RULE_06 RULE_07
        if (!auto_mode && cmd_valid_i && !cmd_busy_i && motor_stopped_i) begin
            st_next.mf_use_set2 = gain_select_i; // RULE_09 RULE_10
        end
        // Host feedforward only passes when combination is enabled
        st_next.sff = combine ? speed_ff_input_i : 16'h0000; // RULE_01 RULE_02
        st_next.fff = combine ? force_ff_input_i : 16'h0000; // RULE_01 RULE_02
        if (wr) begin
            for (int b = 0; b < 2; b++) begin
                wdata16[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : 8'h00;
            end
            protected_hit = st_reg.tuning && (ofs != OFS_MODEL_FOLLOW_SWITCH)
                && (ofs != OFS_CONTROL); // RULE_12 RULE_13
            unique case (ofs)
                OFS_GAIN_SWITCH_SELECT: begin
                    if (!protected_hit && wdata16[3:0] != METHOD_RESERVED) begin
                        st_next.gain_switch_select = wdata16; // RULE_04 RULE_05
                    end
                end
                OFS_MODEL_FOLLOW_SWITCH: begin
                    st_next.model_follow_switch = wdata16; // RULE_12
                end
                OFS_CONTROL: begin
                    if (wb_sel_i[0]) begin
                        st_next.tuning = wb_dat_i[CTRL_TUNING_BIT];
                    end
                    if (wb_sel_i[2] && !st_reg.tuning) begin
                        st_next.ff_gain[7:0] = wb_dat_i[CTRL_FF_GAIN_LSB +: 8];
                    end
                    if (wb_sel_i[3] && !st_reg.tuning) begin
                        st_next.ff_gain[15:8] = wb_dat_i[CTRL_FF_GAIN_LSB+8 +: 8];
                    end
                end
                default: begin
                    for (int i = 0; i < NUM_GAINS; i++) begin
                        if (!protected_hit && ofs == OFS_SET1_BASE + ADDR_W'(4*i)) begin
                            st_next.set1[i] = wdata16;
                        end
                        if (!protected_hit && ofs == OFS_SET2_BASE + ADDR_W'(4*i)) begin
                            st_next.set2[i] = wdata16;
                        end
                    end
                end
            endcase
        end
        if (st_reg.tuning && tune_done_i) begin
            st_next.tuning = 1'b0; // RULE_12
            st_next.model_follow_switch = tuned_mf_switch_i;
            st_next.set1[IDX_MF_GAIN] = tuned_mf_gain_i;
            st_next.freq_a = tuned_freq_a_i;
            st_next.freq_b = tuned_freq_b_i;
        end
        if (rd) begin
            unique case (ofs)
                OFS_GAIN_SWITCH_SELECT: st_next.rdata = {16'h0000, st_reg.gain_switch_select};
                OFS_MODEL_FOLLOW_SWITCH: st_next.rdata = {16'h0000, st_reg.model_follow_switch};
                OFS_CONTROL: st_next.rdata = {st_reg.ff_gain, 15'h0000, st_reg.tuning};
                OFS_STATUS: st_next.rdata = {28'h000_0000, st_reg.sel_latched,
                    st_reg.mf_use_set2, st_reg.use_set2, st_reg.tuning};
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    for (int i = 0; i < NUM_GAINS; i++) begin
                        if (ofs == OFS_SET1_BASE + ADDR_W'(4*i)) begin
                            st_next.rdata = {16'h0000, st_reg.set1[i]};
                        end
                        if (ofs == OFS_SET2_BASE + ADDR_W'(4*i)) begin
                            st_next.rdata = {16'h0000, st_reg.set2[i]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.gain_switch_select <= GAIN_SWITCH_SELECT_RST;
            st_reg.model_follow_switch <= MODEL_FOLLOW_SWITCH_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_GAINS; i++) begin
            gs.set1[i] = st_reg.set1[i];
            gs.set2[i] = st_reg.set2[i];
        end
    end
    assign gs.use_set2 = st_reg.use_set2;
    assign gs.mf_use_set2 = st_reg.mf_use_set2;

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign tuning_o = st_reg.tuning;
    assign speed_ff_o = st_reg.sff;
    assign force_ff_o = st_reg.fff;
    // Feedforward gain is ignored unless host combination is enabled
    assign feedforward_gain_o = combine ? st_reg.ff_gain : 16'h0000; // RULE_01
    assign suppress1_freq_a_o = st_reg.freq_a;
    assign suppress1_freq_b_o = st_reg.freq_b;
    assign active_set2_o = st_reg.use_set2;
    assign mf_set2_o = st_reg.mf_use_set2;
    assign speed_gain_o = gs.active[IDX_SPEED_GAIN];
    assign speed_integral_o = gs.active[IDX_SPEED_INTEGRAL];
    assign position_gain_o = gs.active[IDX_POSITION_GAIN];
    assign force_filter_o = gs.active[IDX_FORCE_FILTER];
    assign mf_gain_o = gs.active[IDX_MF_GAIN];
    assign mf_comp_o = gs.active[IDX_MF_COMP];
    assign friction_comp_o = gs.active[IDX_FRICTION_COMP];

    AST_FF_BLOCKED: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_01
        !combine |-> ##1 (speed_ff_o == 16'h0000 && force_ff_o == 16'h0000))
        else $error("host feedforward leaked while combination off");
    AST_FF_GAIN_OFF: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_01
        !combine |-> feedforward_gain_o == 16'h0000)
        else $error("feedforward gain applied while combination off");
    AST_FF_PASS: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_02
        combine |-> ##1 (speed_ff_o == $past(speed_ff_input_i)))
        else $error("speed feedforward not passed when combined");
    AST_FORCE_FF_PASS: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_02
        combine |-> ##1 (force_ff_o == $past(force_ff_input_i)))
        else $error("force feedforward not passed when combined");
    AST_NO_RESERVED: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_04
        method != METHOD_RESERVED)
        else $error("reserved gain switching method stored");
    AST_RESERVED_REFUSED: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_04
        (wr && ofs == OFS_GAIN_SWITCH_SELECT && wdata16[3:0] == METHOD_RESERVED)
            |-> ##1 $stable(st_reg.gain_switch_select))
        else $error("reserved gain switching code accepted");
    AST_MANUAL_SEL: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_07
        (!auto_mode && cmd_valid_i) |-> ##1 active_set2_o == $past(gain_select_i))
        else $error("manual select did not pick set");
    AST_AUTO_POS: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_14
        (auto_mode && position_ctrl_i) |-> ##1 active_set2_o == $past(auto_cond_a_i))
        else $error("automatic switch not following condition");
    AST_MF_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_09
        (auto_mode || cmd_busy_i || !motor_stopped_i || !cmd_valid_i)
            |-> ##1 $stable(mf_set2_o))
        else $error("model following set changed without conditions");
    AST_MF_SWITCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_10
        (!auto_mode && cmd_valid_i && !cmd_busy_i && motor_stopped_i)
            |-> ##1 mf_set2_o == $past(gain_select_i))
        else $error("model following set missed allowed switch");
    AST_SET_APPLY: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_08
        1'b1 |-> ##1 speed_gain_o == ($past(active_set2_o)
            ? $past(st_reg.set2[IDX_SPEED_GAIN]) : $past(st_reg.set1[IDX_SPEED_GAIN])))
        else $error("speed gain not taken from the selected set");
    AST_TUNE_LOCK: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_13
        (tuning_o && wr && !tune_done_i && ofs == OFS_SET1_BASE + ADDR_W'(4*IDX_MF_GAIN))
            |-> ##1 $stable(st_reg.set1[IDX_MF_GAIN]))
        else $error("protected write accepted during tuning");
    AST_TUNE_LOAD: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_12
        (tuning_o && tune_done_i) |-> ##1 (!tuning_o && suppress1_freq_a_o == $past(tuned_freq_a_i)))
        else $error("tuned values not loaded");
    AST_TUNE_MF_GAIN: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_12
        (tuning_o && tune_done_i) |-> ##1 st_reg.set1[IDX_MF_GAIN] == $past(tuned_mf_gain_i))
        else $error("tuned model following gain not loaded");
    AST_APPLY_NEXT: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE_15
        $rose(active_set2_o) |-> ##1 (position_gain_o == st_reg.set2[IDX_POSITION_GAIN]
            || $changed(st_reg.set2[IDX_POSITION_GAIN])))
        else $error("active set not applied next cycle");
    AST_ACK_PULSE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wb_ack_o |-> ##1 !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule : servo_gain_set_switching
`default_nettype wire

/* File: bench/host_ctrl_model.sv */
/*
 Host motion controller model: issues commands carrying a gain select bit,
 reports command and motion state and supplies feedforward values.
 Assumes the drive samples its command inputs on rising core_clk_i edges.
*/
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model (
    input wire logic core_clk_i,
    output logic cmd_valid_o,
    output logic gain_select_o,
    output logic cmd_busy_o,
    output logic motor_stopped_o,
    output logic [15:0] speed_ff_o,
    output logic [15:0] force_ff_o
);
    initial begin
        cmd_valid_o = 1'b0;
        gain_select_o = 1'b0;
        cmd_busy_o = 1'b0;
        motor_stopped_o = 1'b1;
        speed_ff_o = 16'h1234;
        force_ff_o = 16'h4321;
    end

    // One command pulse; the select line is inverted once the command is gone
    task automatic send_cmd(input logic sel, input logic busy, input logic stopped);
        @(posedge core_clk_i);
        cmd_valid_o <= 1'b1;
        gain_select_o <= sel;
        cmd_busy_o <= busy;
        motor_stopped_o <= stopped;
        @(posedge core_clk_i);
        cmd_valid_o <= 1'b0;
        gain_select_o <= ~sel;
    endtask : send_cmd
endmodule : host_ctrl_model
`default_nettype wire

/* File: bench/servo_gain_set_switching_tb.sv */
/*
 Self-checking bench for gain set switching: registers, manual and automatic
 switching, feedforward combining and tuning. Assumes the host model drives commands.
*/
`timescale 1ns/100ps
`default_nettype none
module servo_gain_set_switching_tb;
    import gain_sw_pkg::*;
    logic core_clk_i, srst_i, cyc, stb, we, pos_ctrl, cond_a, tune_done;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, wb_dat_o;
    logic wb_ack_o, cmd_valid, gsel, busy, stopped, tuning_o, set2_o, mf2_o;
    logic [15:0] tval, sff_in, fff_in, sff_o, fff_o, ffg_o, fa_o, fb_o;
    logic [15:0] gout [NUM_GAINS];
    int failures, tests_run;

    host_ctrl_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid),
        .gain_select_o(gsel), .cmd_busy_o(busy), .motor_stopped_o(stopped),
        .speed_ff_o(sff_in), .force_ff_o(fff_in));
    servo_gain_set_switching uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid),
        .gain_select_i(gsel), .cmd_busy_i(busy), .motor_stopped_i(stopped),
        .position_ctrl_i(pos_ctrl), .auto_cond_a_i(cond_a), .speed_ff_input_i(sff_in),
        .force_ff_input_i(fff_in), .tune_done_i(tune_done), .tuned_mf_switch_i(tval),
        .tuned_mf_gain_i(tval), .tuned_freq_a_i(tval), .tuned_freq_b_i(~tval),
        .tuning_o(tuning_o), .speed_ff_o(sff_o), .force_ff_o(fff_o),
        .feedforward_gain_o(ffg_o), .suppress1_freq_a_o(fa_o), .suppress1_freq_b_o(fb_o),
        .active_set2_o(set2_o), .mf_set2_o(mf2_o), .speed_gain_o(gout[0]),
        .speed_integral_o(gout[1]), .position_gain_o(gout[2]), .force_filter_o(gout[3]),
        .mf_gain_o(gout[4]), .mf_comp_o(gout[5]), .friction_comp_o(gout[6]));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            report_and_stop();
        end
    endtask : wb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdat);
    endtask : rd_chk

    // Set 1 slot i holds 0x1000+i, set 2 slot i holds 0x2000+i
    task automatic chk_gains(input logic [NUM_GAINS-1:0] from2);
        for (int i = 0; i < NUM_GAINS; i++) begin
            chk("gain", {16'h0000, (from2[i] ? 16'h2000 : 16'h1000) + 16'(i)}, {16'h0000, gout[i]});
        end
    endtask : chk_gains

    task automatic wait_set2(input logic v);
        int n;
        n = 0;
        while (set2_o !== v && n < 100) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("auto set2", {31'h0, v}, {31'h0, set2_o});
        if (set2_o !== v) begin
            report_and_stop();
        end
        tick(2);
    endtask : wait_set2

    task automatic t_reset();
        rd_chk("select", OFS_GAIN_SWITCH_SELECT, 32'h0000_0000);
        rd_chk("mf switch", OFS_MODEL_FOLLOW_SWITCH, 32'h0000_0000);
        rd_chk("unmapped", 8'hFC, 32'h0000_0000);
        wb(1'b1, OFS_CONTROL, 32'h0055_0000);
        tick(2);
        chk("speed ff", 32'h0000_0000, {16'h0000, sff_o});
        chk("force ff", 32'h0000_0000, {16'h0000, fff_o});
        chk("ff gain", 32'h0000_0000, {16'h0000, ffg_o});
    endtask : t_reset

    task automatic t_manual();
        for (int i = 0; i < NUM_GAINS; i++) begin
            wb(1'b1, OFS_SET1_BASE + 8'(4 * i), 32'h0000_1000 + i);
            wb(1'b1, OFS_SET2_BASE + 8'(4 * i), 32'h0000_2000 + i);
        end
        host.send_cmd(1'b1, 1'b0, 1'b1);
        tick(1);
        chk("set2", 32'h0000_0001, {31'h0, set2_o});
        tick(1);
        chk_gains(7'h7F);
        rd_chk("status", OFS_STATUS, 32'h0000_000E);
        host.send_cmd(1'b0, 1'b1, 1'b1);
        tick(2);
        chk_gains(7'h30);
        host.send_cmd(1'b0, 1'b0, 1'b0);
        tick(2);
        chk("mf set2", 32'h0000_0001, {31'h0, mf2_o});
        host.send_cmd(1'b0, 1'b0, 1'b1);
        tick(2);
        chk_gains(7'h00);
    endtask : t_manual

    task automatic t_auto();
        wb(1'b1, OFS_GAIN_SWITCH_SELECT, 32'h0000_0001);
        rd_chk("reserved", OFS_GAIN_SWITCH_SELECT, 32'h0000_0000);
        wb(1'b1, OFS_GAIN_SWITCH_SELECT, 32'h0000_0002);
        rd_chk("auto", OFS_GAIN_SWITCH_SELECT, 32'h0000_0002);
        cond_a <= 1'b1;
        tick(8);
        chk("no position", 32'h0000_0000, {31'h0, set2_o});
        pos_ctrl <= 1'b1;
        wait_set2(1'b1);
        chk_gains(7'h4F);
        host.send_cmd(1'b1, 1'b0, 1'b1);
        tick(3);
        chk("ignore cmd", 32'h0000_0001, {31'h0, set2_o});
        chk("auto mf hold", 32'h0000_0000, {31'h0, mf2_o});
        cond_a <= 1'b0;
        wait_set2(1'b0);
        pos_ctrl <= 1'b0;
        wb(1'b1, OFS_GAIN_SWITCH_SELECT, 32'h0000_0000);
    endtask : t_auto

    task automatic t_ff();
        wb(1'b1, OFS_MODEL_FOLLOW_SWITCH, 32'h0000_1000);
        tick(2);
        chk("speed ff", 32'h0000_1234, {16'h0000, sff_o});
        chk("force ff", 32'h0000_4321, {16'h0000, fff_o});
        chk("ff gain", 32'h0000_0055, {16'h0000, ffg_o});
        wb(1'b1, OFS_MODEL_FOLLOW_SWITCH, 32'h0000_0000);
        tick(2);
        chk("speed ff", 32'h0000_0000, {16'h0000, sff_o});
    endtask : t_ff

    task automatic t_tune();
        wb(1'b1, OFS_CONTROL, 32'h0000_0001);
        tick(1);
        chk("tuning", 32'h0000_0001, {31'h0, tuning_o});
        wb(1'b1, OFS_SET1_BASE + 8'h10, 32'h0000_0ABC);
        rd_chk("mf gain", OFS_SET1_BASE + 8'h10, 32'h0000_1004);
        wb(1'b1, OFS_MODEL_FOLLOW_SWITCH, 32'h0000_1000);
        rd_chk("mf switch", OFS_MODEL_FOLLOW_SWITCH, 32'h0000_1000);
        tval <= 16'h0321;
        @(posedge core_clk_i);
        tune_done <= 1'b1;
        @(posedge core_clk_i);
        tune_done <= 1'b0;
        tick(2);
        chk("freq a", 32'h0000_0321, {16'h0000, fa_o});
        chk("freq b", 32'h0000_FCDE, {16'h0000, fb_o});
        rd_chk("tuned switch", OFS_MODEL_FOLLOW_SWITCH, 32'h0000_0321);
        rd_chk("tuned mf gain", OFS_SET1_BASE + 8'h10, 32'h0000_0321);
    endtask : t_tune

    initial begin
        srst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        pos_ctrl = 1'b0;
        cond_a = 1'b0;
        tune_done = 1'b0;
        tval = 16'h0000;
        failures = 0;
        tests_run = 0;
        tick(4);
        srst_i <= 1'b0;
        t_reset();
        t_manual();
        t_auto();
        t_ff();
        t_tune();
        report_and_stop();
    end
endmodule : servo_gain_set_switching_tb
`default_nettype wire
